// ===== common/sac_pkg.sv
// Shared constants and types for the simultaneous conversion readout block
// Function
// - Span select high picks the 20 V range, low picks 10 V, all channels.
// - Port type select low enables parallel readout, high enables serial readout.
// - In serial mode the read strobe is the shift clock; two lanes carry data.
// - Start A rising puts channels 1-4 in hold; start B does channels 5-8.
// - Busy rises after both start edges and stays high until all eight convert.
// - Busy falling latches results into output registers, readable after a delay.
// - Start edges are ignored while busy is high.
// - Parallel bus is driven only while chip select and read strobe are low.
// - Each 18-bit result takes two strobes: bits 17..2, then bits 1..0.
// - Serial chip select falling enables both lanes and presents the MSB.
// - Each shift clock rising edge puts the next bit on both lanes.
// - A reset pulse during a conversion aborts it.
// - A reset pulse during a readout clears all result registers to zero.
// - Marker floats while chip select high, driven from chip select falling.
// - Parallel marker high on strobe fall for channel 1, low after third fall.
// - Serial marker high at chip select fall, low on 18th shift clock fall.
// - Power-down request picks standby or shutdown by span select level.
// - First strobe maps result bits 17..2 onto bus pins 15..0.
// - Second strobe puts bits 1,0 on pins 15,14; other pins zero.
// - Three-bit oversample select, bit 2 most significant, picks the ratio.
package sac_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_CH           = 8;
    localparam int RES_W            = 18;
    localparam int BUS_W            = 16;
    localparam int OS_W             = 3;
    localparam int FIFO_DEPTH       = 4;
    localparam int LANE_BITS        = 72;
    localparam int GROUP_CH         = 4;
    localparam int LOW_BITS         = 2;
    localparam logic [3:0] LAST_WORD      = 4'hF;
    localparam logic [3:0] MARKER_WORDS   = 4'h2;
    localparam logic [4:0] MARKER_FALLS   = 5'h12;
    localparam logic [6:0] LAST_BIT       = 7'h47;
    localparam logic [2:0] LAST_CH        = 3'h7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS          = 8;
    localparam int POST_BUSY_READ_DELAY_NS = 15;
    localparam int POST_BUSY_READ_DELAY_CYC =
        (POST_BUSY_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 4;

    // ------------------------------------------------------------
    // Synchronised pin bundle
    // ------------------------------------------------------------
    localparam int SYNC_W   = 11;
    localparam int S_RST    = 0;
    localparam int S_STA    = 1;
    localparam int S_STB    = 2;
    localparam int S_CS_N   = 3;
    localparam int S_RD_N   = 4;
    localparam int S_PTS    = 5;
    localparam int S_SPAN   = 6;
    localparam int S_PDR_N  = 7;
    localparam int S_OS     = 8;
    // Read strobe and chip select idle high, so no false edge after reset
    localparam logic [SYNC_W-1:0] SYNC_RST = 11'h0D8;

    typedef enum logic [0:0] {
        SAC_IDLE    = 1'b0,
        SAC_CONVERT = 1'b1
    } sac_fsm_t;
endpackage : sac_pkg

// ===== verilog/sac_sync.sv
// Three-stage pin synchroniser with agreement filter
module sac_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_val
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } sac_sync_state_t;

    sac_sync_state_t q, d;

    always_comb begin
        d    = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // A change counts only once the second and third stages agree
        d.val = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.val);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '{s1: RST, s2: RST, s3: RST, val: RST};
        end else begin
            q <= d;
        end
    end

    assign pin_val = q.val;
endmodule : sac_sync

// ===== verilog/sac_fifo.sv
// Result word FIFO between conversion core and result staging
module sac_fifo #(
    parameter int W = 18,
    parameter int D = 4
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         clear,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic      [W-1:0] out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wr;
        logic [AW-1:0]       rd;
        logic [CW-1:0]       cnt;
        logic                in_rdy;
    } sac_fifo_state_t;

    sac_fifo_state_t q, d;
    logic push;
    logic pop;

    always_comb begin
        d    = q;
        push = in_valid && q.in_rdy;
        pop  = out_ready && (q.cnt != '0);
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr        = (q.wr == AW'(D - 1)) ? '0 : q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = (q.rd == AW'(D - 1)) ? '0 : q.rd + 1'b1;
        end
        d.cnt = q.cnt + CW'(push) - CW'(pop);
        if (clear) begin
            d.wr  = '0;
            d.rd  = '0;
            d.cnt = '0;
        end
        // Registered ready from the next count: full shows with no lag, never overrun
        d.in_rdy = (d.cnt != CW'(D));
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_ready  = q.in_rdy;
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rd];
endmodule : sac_fifo

// ===== verilog/sac_top.sv
// Conversion control and parallel/serial result readout
module sac_top (
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          host_reset_pin,
    input  wire logic                          sample_start_group_a,
    input  wire logic                          sample_start_group_b,
    input  wire logic                          chip_select_n,
    input  wire logic                          read_strobe_n,
    input  wire logic                          port_type_select,
    input  wire logic                          span_select,
    input  wire logic                          power_down_request_n,
    input  wire logic [sac_pkg::OS_W-1:0]      oversample_ratio_select,
    input  wire logic [sac_pkg::RES_W-1:0]     core_result_data,
    input  wire logic                          core_result_valid,
    output logic                               core_result_ready,
    output logic                               core_start,
    output logic                               busy,
    output logic                               hold_group_a,
    output logic                               hold_group_b,
    output logic                               results_readable,
    output logic [sac_pkg::BUS_W-1:0]          parallel_result_bus,
    output logic                               parallel_result_bus_oe_n,
    output logic                               serial_lane_a,
    output logic                               serial_lane_b,
    output logic                               serial_lane_oe_n,
    output logic                               first_channel_marker,
    output logic                               first_channel_marker_oe_n,
    output logic                               range_wide,
    output logic                               standby_mode,
    output logic                               shutdown_mode,
    output logic [sac_pkg::OS_W-1:0]           oversample_ratio
);
    import sac_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sac_fsm_t                        fsm;
        logic [SYNC_W-1:0]               prev;
        logic                            seen_a;
        logic                            seen_b;
        logic [2:0]                      ch_cnt;
        logic [NUM_CH-1:0][RES_W-1:0]    stage;
        logic [NUM_CH-1:0][RES_W-1:0]    result;
        logic [SETTLE_W-1:0]             settle;
        logic                            readable;
        logic [3:0]                      word_idx;
        logic [6:0]                      bit_cnt;
        logic [4:0]                      fall_cnt;
        logic                            busy;
        logic                            hold_a;
        logic                            hold_b;
        logic                            start;
        logic [BUS_W-1:0]                bus;
        logic                            bus_oe_n;
        logic                            lane_a;
        logic                            lane_b;
        logic                            lane_oe_n;
        logic                            marker;
        logic                            marker_oe_n;
        logic                            range_wide;
        logic                            standby;
        logic                            shutdown;
        logic [OS_W-1:0]                 os;
    } sac_top_state_t;

    sac_top_state_t q, d;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] sv;

    assign pins = {oversample_ratio_select, power_down_request_n, span_select,
                   port_type_select, read_strobe_n, chip_select_n,
                   sample_start_group_b, sample_start_group_a, host_reset_pin};

    sac_sync #(
        .W   (SYNC_W),
        .RST (SYNC_RST)
    ) u_sync (
        .clk     (clk),
        .reset   (reset),
        .pin_in  (pins),
        .pin_val (sv)
    );

    // ------------------------------------------------------------
    // Result FIFO
    // ------------------------------------------------------------
    logic             fifo_clear;
    logic             fifo_out_ready;
    logic             fifo_out_valid;
    logic [RES_W-1:0] fifo_out_data;

    sac_fifo #(
        .W (RES_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .clear     (fifo_clear),
        .in_data   (core_result_data),
        .in_valid  (core_result_valid),
        .in_ready  (core_result_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready)
    );

    // ------------------------------------------------------------
    // Edge detection and readout helpers
    // ------------------------------------------------------------
    logic                 rst_rise;
    logic                 sta_rise;
    logic                 stb_rise;
    logic                 cs_fall;
    logic                 cs_rise;
    logic                 rd_fall;
    logic                 rd_rise;
    logic                 cs_low;
    logic                 serial;
    logic [LANE_BITS-1:0] flat_a;
    logic [LANE_BITS-1:0] flat_b;
    logic [RES_W-1:0]     word_res;
    logic [BUS_W-1:0]     word_bus;

    assign rst_rise = sv[S_RST] && !q.prev[S_RST];
    assign sta_rise = sv[S_STA] && !q.prev[S_STA];
    assign stb_rise = sv[S_STB] && !q.prev[S_STB];
    assign cs_fall  = !sv[S_CS_N] && q.prev[S_CS_N];
    assign cs_rise  = sv[S_CS_N] && !q.prev[S_CS_N];
    assign rd_fall  = !sv[S_RD_N] && q.prev[S_RD_N];
    assign rd_rise  = sv[S_RD_N] && !q.prev[S_RD_N];
    assign cs_low   = !sv[S_CS_N];
    assign serial   = sv[S_PTS];

    // Lane A carries channels 1-4, lane B 5-8, channel order MSB first
    assign flat_a   = {q.result[0], q.result[1], q.result[2], q.result[3]};
    assign flat_b   = {q.result[4], q.result[5], q.result[6], q.result[7]};
    assign word_res = q.result[q.word_idx[3:1]];
    assign word_bus = q.word_idx[0]
                    ? {word_res[LOW_BITS-1:0], {(BUS_W-LOW_BITS){1'b0}}}
                    : word_res[RES_W-1:LOW_BITS];

    assign fifo_out_ready = (q.fsm == SAC_CONVERT);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d          = q;
        d.prev     = sv;
        d.start    = 1'b0;
        fifo_clear = 1'b0;

        // Mode pins follow at once; the host keeps span stable mid-conversion
        d.range_wide = sv[S_SPAN];
        d.standby    = !sv[S_PDR_N] && sv[S_SPAN];
        d.shutdown   = !sv[S_PDR_N] && !sv[S_SPAN];
        d.os         = sv[S_OS +: OS_W];

        // --------------------------------------------------------
        // Start handling
        // --------------------------------------------------------
        // Edges while busy are dropped, not remembered
        if (!q.busy) begin
            if (sta_rise) begin
                d.seen_a = 1'b1;
                d.hold_a = 1'b1;
            end
            if (stb_rise) begin
                d.seen_b = 1'b1;
                d.hold_b = 1'b1;
            end
            // Split starts rely on the host keeping oversampling off
            if (d.seen_a && d.seen_b) begin
                d.busy   = 1'b1;
                d.start  = 1'b1;
                d.fsm    = SAC_CONVERT;
                d.ch_cnt = '0;
                d.seen_a = 1'b0;
                d.seen_b = 1'b0;
            end
        end

        // --------------------------------------------------------
        // Conversion results
        // --------------------------------------------------------
        if (q.fsm == SAC_CONVERT && fifo_out_valid) begin
            d.stage[q.ch_cnt] = fifo_out_data;
            d.ch_cnt          = q.ch_cnt + 1'b1;
            if (q.ch_cnt == LAST_CH) begin
                // A read still open here sees the new data mid-transfer
                d.result   = d.stage;
                d.busy     = 1'b0;
                d.hold_a   = 1'b0;
                d.hold_b   = 1'b0;
                d.fsm      = SAC_IDLE;
                d.word_idx = '0;
                d.settle   = SETTLE_W'(POST_BUSY_READ_DELAY_CYC);
                d.readable = 1'b0;
            end
        end

        // Results count as readable only after the post-busy delay
        if (q.settle != '0) begin
            d.settle = q.settle - 1'b1;
            if (q.settle == SETTLE_W'(1)) begin
                d.readable = 1'b1;
            end
        end

        // --------------------------------------------------------
        // Readout framing
        // --------------------------------------------------------
        if (cs_fall) begin
            d.marker_oe_n = 1'b0;
            d.marker      = serial;
            d.bit_cnt     = '0;
            d.fall_cnt    = '0;
            if (serial) begin
                d.lane_a = flat_a[LANE_BITS-1];
                d.lane_b = flat_b[LANE_BITS-1];
            end
        end
        if (cs_rise) begin
            d.marker_oe_n = 1'b1;
            d.marker      = 1'b0;
        end

        // Parallel: two strobes per channel, pointer moves on strobe release
        if (!serial && cs_low) begin
            if (rd_fall) begin
                d.bus    = word_bus;
                d.marker = (q.word_idx < MARKER_WORDS);
            end
            if (rd_rise) begin
                d.word_idx = (q.word_idx == LAST_WORD) ? '0 : q.word_idx + 1'b1;
            end
        end
        d.bus_oe_n = !(!serial && cs_low && !sv[S_RD_N]);

        // Serial: strobe pin is the shift clock, lanes drive serial_lane_a and serial_lane_b
        if (serial && cs_low && !cs_fall) begin
            if (rd_rise && q.bit_cnt != LAST_BIT) begin
                d.bit_cnt = q.bit_cnt + 1'b1;
                d.lane_a  = flat_a[LAST_BIT - q.bit_cnt - 1'b1];
                d.lane_b  = flat_b[LAST_BIT - q.bit_cnt - 1'b1];
            end
            if (rd_fall && q.fall_cnt != MARKER_FALLS) begin
                d.fall_cnt = q.fall_cnt + 1'b1;
                if (d.fall_cnt == MARKER_FALLS) begin
                    d.marker = 1'b0;
                end
            end
        end
        d.lane_oe_n = !(serial && cs_low);

        // --------------------------------------------------------
        // Host reset pulse, acts on its rising edge
        // --------------------------------------------------------
        if (rst_rise) begin
            d.fsm      = SAC_IDLE;
            d.busy     = 1'b0;
            d.start    = 1'b0;
            d.hold_a   = 1'b0;
            d.hold_b   = 1'b0;
            d.seen_a   = 1'b0;
            d.seen_b   = 1'b0;
            d.ch_cnt   = '0;
            d.settle   = '0;
            d.word_idx = '0;
            fifo_clear = 1'b1;
            if (cs_low) begin
                d.result = '0;
                d.bus    = '0;
                d.lane_a = 1'b0;
                d.lane_b = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            q             <= '0;
            q.prev        <= SYNC_RST;
            q.bus_oe_n    <= 1'b1;
            q.lane_oe_n   <= 1'b1;
            q.marker_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign core_start                = q.start;
    assign busy                      = q.busy;
    assign hold_group_a              = q.hold_a;
    assign hold_group_b              = q.hold_b;
    assign results_readable          = q.readable;
    assign parallel_result_bus       = q.bus;
    assign parallel_result_bus_oe_n  = q.bus_oe_n;
    assign serial_lane_a             = q.lane_a;
    assign serial_lane_b             = q.lane_b;
    assign serial_lane_oe_n          = q.lane_oe_n;
    assign first_channel_marker      = q.marker;
    assign first_channel_marker_oe_n = q.marker_oe_n;
    assign range_wide                = q.range_wide;
    assign standby_mode              = q.standby;
    assign shutdown_mode             = q.shutdown;
    assign oversample_ratio          = q.os;
endmodule : sac_top

// ===== verif/sac_top_sva.sv
// Port assertions for the conversion readout block
module sac_top_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic core_start,
    input wire logic busy,
    input wire logic hold_group_a,
    input wire logic hold_group_b,
    input wire logic results_readable,
    input wire logic parallel_result_bus_oe_n,
    input wire logic serial_lane_oe_n,
    input wire logic first_channel_marker,
    input wire logic first_channel_marker_oe_n,
    input wire logic range_wide,
    input wire logic standby_mode,
    input wire logic shutdown_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    busy_holds_a: assert property (busy |-> hold_group_a && hold_group_b)
        else $error("busy without holds");
    busy_start_a: assert property ($rose(busy) |-> core_start)
        else $error("busy rose without start");
    start_ignored_a: assert property (busy && $past(busy) |-> !core_start)
        else $error("start taken while busy");
    latch_delay_a: assert property ($fell(busy) |-> ##[1:3] results_readable)
        else $error("results not readable");
    lanes_excl_a: assert property (parallel_result_bus_oe_n || serial_lane_oe_n)
        else $error("both ports driving");
    marker_drive_a: assert property (first_channel_marker |-> !first_channel_marker_oe_n)
        else $error("marker high while floating");
    standby_span_a: assert property (standby_mode |-> range_wide)
        else $error("standby with narrow span");
    shutdown_span_a: assert property (shutdown_mode |-> !range_wide && !standby_mode)
        else $error("shutdown with wide span");
endmodule : sac_top_sva

bind sac_top sac_top_sva sac_top_sva_i (.*);

// ===== verif/sac_core_model.sv
// Conversion core stand-in streaming eight results per start
module sac_core_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        core_start,
    input  wire logic        core_result_ready,
    output logic      [17:0] core_result_data,
    output logic             core_result_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  cnt_q;
    logic [17:0] pat;
    // Distinct value per channel so an order slip shows up
    assign pat = 18'h2C3A5 + 18'(cnt_q) * 18'h0F0F3;
    assign core_result_valid = !cnt_q[3];
    // Idle data inverted so a stale word never passes for a result
    assign core_result_data = core_result_valid ? pat : ~pat;
    always_ff @(posedge clk) begin
        if (reset || core_start) begin
            cnt_q <= reset ? 4'h8 : 4'h0;
        end else if (core_result_valid && core_result_ready) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : sac_core_model

// ===== verif/sac_top_tb_top.sv
// Bench for the conversion readout block
module sac_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, reset = 1'h1, host_reset_pin = 1'h0, chip_select_n = 1'h1;
    logic sample_start_group_a = 1'h0, sample_start_group_b = 1'h0, read_strobe_n = 1'h1;
    logic port_type_select = 1'h0, span_select = 1'h1, power_down_request_n = 1'h1;
    logic [2:0] oversample_ratio_select = 3'h0, oversample_ratio;
    logic [17:0] core_result_data, w, x;
    logic [15:0] parallel_result_bus;
    logic core_result_valid, core_result_ready, core_start, busy, hold_group_a;
    logic hold_group_b, results_readable, parallel_result_bus_oe_n, serial_lane_a;
    logic serial_lane_b, serial_lane_oe_n, first_channel_marker, first_channel_marker_oe_n;
    logic range_wide, standby_mode, shutdown_mode;
    int mismatches = 0, samples_checked = 0;
    // Last row leaves oversampling off so the starts may be split
    logic [7:0] rows [4] = '{8'hAE, 8'h19, 8'h78, 8'hC4};
    sac_top sac_top_i (.*);
    sac_core_model sac_core_model_i (.*);
    always #4 clk = ~clk;
    function automatic logic [17:0] res(int c);
        return 18'h2C3A5 + 18'(c) * 18'h0F0F3;
    endfunction : res
    task automatic chk(logic [17:0] got, logic [17:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %h %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic complete_run;
        $display("compares %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    initial begin
        cyc(20);
        reset = 1'h0;
        cyc(6);
        // Host pulse after power-up, about 100 ns, before any start
        host_reset_pin = 1'h1;
        cyc(13);
        host_reset_pin = 1'h0;
        cyc(8);
        foreach (rows[i]) begin
            {span_select, power_down_request_n, oversample_ratio_select} = rows[i][7:3];
            cyc(6);
            chk({range_wide, standby_mode, shutdown_mode}, rows[i][2:0]);
            chk(oversample_ratio, rows[i][5:3]);
        end
        $display("modes done");
        sample_start_group_a = 1'h1;
        cyc(6);
        chk({hold_group_a, hold_group_b, busy}, 3'h4);
        sample_start_group_b = 1'h1;
        cyc(6);
        chk({hold_group_b, busy}, 2'h3);
        for (int i = 0; busy && i < 200; i++) cyc(1);
        chk(busy, 18'h0);
        if (busy) complete_run();
        cyc(3);
        chk(results_readable, 18'h1);
        $display("conversion done");
        chip_select_n = 1'h0;
        cyc(8);
        chk(first_channel_marker_oe_n, 18'h0);
        for (int k = 0; k < 16; k++) begin
            w = res(k / 2);
            read_strobe_n = 1'h0;
            cyc(8);
            chk(parallel_result_bus, k[0] ? {w[1:0], 14'h0} : w[17:2]);
            chk({parallel_result_bus_oe_n, first_channel_marker}, {1'h0, k < 2});
            read_strobe_n = 1'h1;
            cyc(8);
            chk(parallel_result_bus_oe_n, 18'h1);
        end
        chip_select_n = 1'h1;
        $display("parallel done");
        port_type_select = 1'h1;
        w = res(0);
        x = res(4);
        cyc(8);
        chip_select_n = 1'h0;
        cyc(8);
        chk({serial_lane_oe_n, parallel_result_bus_oe_n}, 2'h1);
        for (int i = 1; i <= 18; i++) begin
            read_strobe_n = 1'h0;
            cyc(2);
            chk({first_channel_marker, serial_lane_a, serial_lane_b}, {1'h1, w[18-i], x[18-i]});
            cyc(2);
            read_strobe_n = 1'h1;
            cyc(4);
        end
        chk(first_channel_marker, 18'h0);
        $display("serial done");
        host_reset_pin = 1'h1;
        cyc(13);
        host_reset_pin = 1'h0;
        cyc(8);
        chip_select_n = 1'h1;
        cyc(8);
        chk(first_channel_marker_oe_n, 18'h1);
        chip_select_n = 1'h0;
        cyc(8);
        chk({serial_lane_a, serial_lane_b}, 2'h0);
        $display("reset done");
        // Abort: host pulse lands a few cycles into a conversion
        sample_start_group_a = 1'h0;
        sample_start_group_b = 1'h0;
        cyc(8);
        sample_start_group_a = 1'h1;
        sample_start_group_b = 1'h1;
        cyc(2);
        host_reset_pin = 1'h1;
        cyc(4);
        chk(busy, 18'h1);
        cyc(2);
        chk({busy, hold_group_a, hold_group_b}, 3'h0);
        cyc(7);
        chk(core_result_ready, 18'h0);
        host_reset_pin = 1'h0;
        cyc(8);
        $display("abort done");
        complete_run();
    end
endmodule : sac_top_tb_top
